/* File: lcd_link_cfg.svh */
// constants shared by both ends of the serial matrix display link
`ifndef LCD_LINK_CFG_SVH
`define LCD_LINK_CFG_SVH

// matrix geometry
`define LCD_ROWS         16
`define LCD_COLS         16
`define CHAIN_LEN        32
`define ROW_IDX_W        4

// reference clock rate
`define REF_CLK_HZ       40000000
`define REF_CLK_MHZ      (`REF_CLK_HZ / 1000000)

// flicker-free refresh per backplane, times backplanes, two halves
`define REFRESH_HZ       30
`define FRAME_HALF_CYC   (`REF_CLK_HZ / (2 * `REFRESH_HZ * `LCD_ROWS))
`define OSC_CNT_W        17

// shift clock half period, least time, rounded up to cycles
`define SCLK_HALF_NS     350
`define SCLK_HALF_CYC    ((`SCLK_HALF_NS * `REF_CLK_MHZ + 999) / 1000)
`define HALF_CNT_W       5

// quiet time after a frame rise before the first shift clock fall
`define GUARD_NS         2000
`define GUARD_CYC        ((`GUARD_NS * `REF_CLK_MHZ + 999) / 1000)
`define GUARD_CNT_W      8

// cycles the shift toggle must stand still before the copy is trusted
`define SETTLE_CYC       3
`define SETTLE_CNT_W     2

// reset values
`define SHIFT_RST        32'h0000_0000
`define LATCH_RST        32'h0000_0000

`endif

/* File: lcd_link_pkg.sv */
// types shared by both ends of the serial matrix display link
package lcd_link_pkg;

    // row driver level: full high, ground, or half supply
    typedef enum logic [1:0] {
        LVL_LOW  = 2'b00,
        LVL_HIGH = 2'b01,
        LVL_MID  = 2'b10
    } drive_level_e;

    // controller load sequence
    typedef enum logic [1:0] {
        HST_IDLE  = 2'b00,
        HST_GUARD = 2'b01,
        HST_LOAD  = 2'b10
    } host_state_e;

    // one bit per chain stage
    typedef logic [31:0] chain_t;

endpackage

/* File: lcd_link_if.sv */
// wires between the display driver and its controller
`timescale 1ns/1ps
interface lcd_link_if;

    logic shift_clk;            // serial shift clock, made by the host
    logic serial_data;          // serial data bit
    logic shift_clock_gate;     // high lets the device shift
    logic frame_request;        // refresh request from the device
    logic phase_host_out;       // host drive level of the phase pin
    logic phase_host_oe;        // host drives the phase pin
    logic phase_dev_out;        // device oscillator level on the pin
    logic phase_dev_oe;         // device oscillator drives the pin
    logic backplane_phase_pin;  // resolved pin level

    // a driving host overpowers the weak on-chip oscillator
    assign backplane_phase_pin = phase_host_oe ? phase_host_out :
                                 (phase_dev_oe ? phase_dev_out : 1'b0);

    // documented device end
    modport dev_mp (
        input  shift_clk,
        input  serial_data,
        input  shift_clock_gate,
        input  backplane_phase_pin,
        output frame_request,
        output phase_dev_out,
        output phase_dev_oe
    );

    // controlling microcomputer end
    modport host_mp (
        output shift_clk,
        output serial_data,
        output shift_clock_gate,
        output phase_host_out,
        output phase_host_oe,
        input  frame_request
    );

endinterface

/* File: matrix_drv_device.sv */
// device end: serially loaded 16 x 16 multiplexed matrix display driver
`timescale 1ns/1ps
`include "lcd_link_cfg.svh"

module matrix_drv_device
    import lcd_link_pkg::*;
#(
    parameter int FRAME_HALF_CYC = `FRAME_HALF_CYC  // oscillator half period
)(
    input  wire logic  ref_clk_i,                // 40 MHz core clock
    input  wire logic  resetn_i,                 // async reset, low
    lcd_link_if.dev_mp link,                     // pins to the host
    output drive_level_e row_level_o [`LCD_ROWS], // row driver levels
    output logic [`LCD_COLS-1:0] col_high_o      // column at high level
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////

    // link domain, clocked by the shift clock
    chain_t shift_reg;                      // serial chain
    chain_t shift_next;                     // chain next value
    logic   shift_tgl_reg;                  // flips on each shift
    logic   shift_tgl_next;                 // toggle next value

    // core domain, crossing of the shift activity
    logic   tgl_meta_reg;                   // first sync stage
    logic   tgl_sync_reg;                   // second sync stage
    logic   tgl_last_reg;                   // previous synced toggle
    logic   tgl_meta_next;                  // first stage next
    logic   tgl_sync_next;                  // second stage next
    logic   tgl_last_next;                  // previous toggle next
    logic [`SETTLE_CNT_W-1:0] settle_reg;   // quiet cycles counted
    logic [`SETTLE_CNT_W-1:0] settle_next;  // quiet count next
    chain_t mirror_reg;                     // settled chain copy
    chain_t mirror_next;                    // copy next value

    // core domain, phase pin and oscillator
    logic   pin_meta_reg;                   // first pin sync stage
    logic   pin_sync_reg;                   // second pin sync stage
    logic   pin_meta_next;                  // first stage next
    logic   pin_sync_next;                  // second stage next
    logic [`OSC_CNT_W-1:0] osc_cnt_reg;     // oscillator half counter
    logic [`OSC_CNT_W-1:0] osc_cnt_next;    // counter next value
    logic   osc_reg;                        // oscillator level
    logic   osc_next;                       // oscillator next
    logic   frame_reg;                      // frame request level
    logic   frame_next;                     // frame next value
    logic   frame_rise;                     // frame about to rise

    // core domain, display latches and drivers
    chain_t latch_reg;                      // display latches
    chain_t latch_next;                     // latch next value
    drive_level_e row_reg  [`LCD_ROWS];     // registered row levels
    drive_level_e row_next [`LCD_ROWS];     // row level next values
    logic [`LCD_COLS-1:0] col_reg;          // registered columns
    logic [`LCD_COLS-1:0] col_next;         // column next values

    // half period in counter width
    localparam logic [`OSC_CNT_W-1:0] OSC_LAST =
        `OSC_CNT_W'(FRAME_HALF_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // helper decoding
    ////////////////////////////////////////////////////////////////////

    // row level from its latch bit and the frame phase
    function automatic drive_level_e row_level(input logic sel,
                                               input logic phase);
        drive_level_e lvl;
        lvl = LVL_MID;                          // unselected: half supply
        if (sel) begin
            lvl = phase ? LVL_LOW : LVL_HIGH;   // opposite to the frame
        end
        return lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // link domain: serial chain
    ////////////////////////////////////////////////////////////////////

    // next chain value, taken on the falling shift clock edge
    always_comb begin
        shift_next     = shift_reg;
        shift_tgl_next = shift_tgl_reg;
        if (link.shift_clock_gate) begin
            // new bit enters at row 1 end
            shift_next     = {shift_reg[`CHAIN_LEN-2:0], link.serial_data};
            shift_tgl_next = ~shift_tgl_reg;    // tell the core a shift
        end
    end

    always_ff @(negedge link.shift_clk or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_reg     <= `SHIFT_RST;
            shift_tgl_reg <= 1'b0;
        end else begin
            shift_reg     <= shift_next;
            shift_tgl_reg <= shift_tgl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core domain: crossing of the chain contents
    ////////////////////////////////////////////////////////////////////

    // the chain is only copied once its toggle has stood still, so a
    // copy never catches bits mid-shift; a stopped clock keeps it valid
    always_comb begin
        tgl_meta_next = shift_tgl_reg;          // first stage only
        tgl_sync_next = tgl_meta_reg;           // second stage
        tgl_last_next = tgl_sync_reg;           // for change detection
        settle_next   = settle_reg;
        mirror_next   = mirror_reg;
        if (tgl_sync_reg != tgl_last_reg) begin
            settle_next = '0;                   // shifting, restart count
        end else if (settle_reg != `SETTLE_CNT_W'(`SETTLE_CYC)) begin
            settle_next = settle_reg + `SETTLE_CNT_W'(1);
            // one copy per quiet spell, never while bits move
            if (settle_reg == `SETTLE_CNT_W'(`SETTLE_CYC - 1)) begin
                mirror_next = shift_reg;        // chain quiet, copy it
            end
        end
    end

    // crossing registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tgl_meta_reg <= 1'b0;
            tgl_sync_reg <= 1'b0;
            tgl_last_reg <= 1'b0;
            settle_reg   <= '0;
            mirror_reg   <= `SHIFT_RST;
        end else begin
            tgl_meta_reg <= tgl_meta_next;
            tgl_sync_reg <= tgl_sync_next;
            tgl_last_reg <= tgl_last_next;
            settle_reg   <= settle_next;
            mirror_reg   <= mirror_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core domain: oscillator and frame request
    ////////////////////////////////////////////////////////////////////

    // on-chip oscillator, pin sync and frame level
    always_comb begin
        pin_meta_next = link.backplane_phase_pin;   // first stage only
        pin_sync_next = pin_meta_reg;               // second stage
        osc_cnt_next  = osc_cnt_reg + `OSC_CNT_W'(1);
        osc_next      = osc_reg;
        if (osc_cnt_reg == OSC_LAST) begin
            osc_cnt_next = '0;
            osc_next     = ~osc_reg;
        end
        frame_next = pin_sync_reg;
    end

    // a rise of the frame level is the transfer moment
    assign frame_rise = frame_next & ~frame_reg;

    // oscillator and frame registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            osc_cnt_reg  <= '0;
            osc_reg      <= 1'b0;
            frame_reg    <= 1'b0;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
            osc_cnt_reg  <= osc_cnt_next;
            osc_reg      <= osc_next;
            frame_reg    <= frame_next;
        end
    end

    // the oscillator drives the pin weakly; a host drive wins
    assign link.phase_dev_out = osc_reg;
    assign link.phase_dev_oe  = 1'b1;
    assign link.frame_request = frame_reg;

    ////////////////////////////////////////////////////////////////////
    // core domain: display latches
    ////////////////////////////////////////////////////////////////////

    // latch load at the frame rise
    always_comb begin
        latch_next = latch_reg;
        if (frame_rise) begin
            latch_next = mirror_reg;
        end
    end

    // display latch register
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            latch_reg <= `LATCH_RST;
        end else begin
            latch_reg <= latch_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core domain: row and column drivers
    ////////////////////////////////////////////////////////////////////

    // sixteen rows and sixteen columns
    // row r+1 sits at chain bit r, column c+1 at chain bit 16+c
    for (genvar r = 0; r < `LCD_ROWS; r++) begin : g_row
        assign row_next[r] = row_level(latch_next[r], frame_next);
    end

    // column levels from the latched bits
    for (genvar c = 0; c < `LCD_COLS; c++) begin : g_col
        assign col_next[c] = latch_next[`LCD_ROWS + c] ? frame_next
                                                       : ~frame_next;
    end

    // driver registers, updated with the frame level
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < `LCD_ROWS; i++) begin
                row_reg[i] <= LVL_MID;          // nothing selected
            end
            col_reg <= '1;                      // blank, frame low
        end else begin
            row_reg <= row_next;
            col_reg <= col_next;
        end
    end

    assign row_level_o = row_reg;
    assign col_high_o  = col_reg;

endmodule

/* File: matrix_drv_host.sv */
// host end: controller that refreshes the matrix driver row by row
`timescale 1ns/1ps
`include "lcd_link_cfg.svh"

module matrix_drv_host
    import lcd_link_pkg::*;
#(
    parameter int FRAME_HALF_CYC = `FRAME_HALF_CYC  // own phase half period
)(
    input  wire logic  ref_clk_i,                  // 40 MHz core clock
    input  wire logic  resetn_i,                   // async reset, low
    input  wire logic  drive_phase_i,              // host drives phase pin
    input  wire logic [`LCD_COLS-1:0] col_data_i,  // next row columns
    input  wire logic  col_valid_i,                // column data offered
    output logic       col_taken_o,                // columns accepted
    output logic [`ROW_IDX_W-1:0] row_index_o,     // row being loaded
    output logic       busy_o,                     // load in progress
    lcd_link_if.host_mp link                       // pins to the device
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////

    host_state_e state_reg, state_next;             // load sequence
    logic        frm_meta_reg, frm_meta_next;       // frame sync 1
    logic        frm_sync_reg, frm_sync_next;       // frame sync 2
    logic        frm_last_reg, frm_last_next;       // previous frame
    logic [`GUARD_CNT_W-1:0] guard_reg, guard_next; // quiet counter
    logic [`HALF_CNT_W-1:0]  half_reg, half_next;   // half clock count
    logic [5:0]  bit_reg, bit_next;                 // bits remaining
    chain_t      word_reg, word_next;               // outgoing chain
    logic        sclk_reg, sclk_next;               // shift clock
    logic        data_reg, data_next;               // serial bit
    logic        gate_reg, gate_next;               // shift gate
    logic        taken_reg, taken_next;             // accept pulse
    logic        busy_reg, busy_next;               // load in progress
    logic [`ROW_IDX_W-1:0] row_reg, row_next;       // row counter
    logic [`OSC_CNT_W-1:0] ph_cnt_reg, ph_cnt_next; // phase counter
    logic        ph_reg, ph_next;                   // own phase level
    logic        ph_oe_reg, ph_oe_next;             // phase drive on

    localparam logic [`OSC_CNT_W-1:0] PH_LAST =
        `OSC_CNT_W'(FRAME_HALF_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // own phase source and frame request sync
    ////////////////////////////////////////////////////////////////////

    always_comb begin
        ph_cnt_next   = ph_cnt_reg + `OSC_CNT_W'(1);
        ph_next       = ph_reg;
        ph_oe_next    = drive_phase_i;
        frm_meta_next = link.frame_request;     // first stage only
        frm_sync_next = frm_meta_reg;
        frm_last_next = frm_sync_reg;
        if (ph_cnt_reg == PH_LAST) begin
            ph_cnt_next = '0;
            ph_next     = ~ph_reg;
        end
    end

    // phase and sync registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ph_cnt_reg   <= '0;
            ph_reg       <= 1'b0;
            ph_oe_reg    <= 1'b0;
            frm_meta_reg <= 1'b0;
            frm_sync_reg <= 1'b0;
            frm_last_reg <= 1'b0;
        end else begin
            ph_cnt_reg   <= ph_cnt_next;
            ph_reg       <= ph_next;
            ph_oe_reg    <= ph_oe_next;
            frm_meta_reg <= frm_meta_next;
            frm_sync_reg <= frm_sync_next;
            frm_last_reg <= frm_last_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // row load sequence
    ////////////////////////////////////////////////////////////////////

    // load one row per frame rise
    always_comb begin
        state_next = state_reg;
        guard_next = guard_reg;
        half_next  = half_reg;
        bit_next   = bit_reg;
        word_next  = word_reg;
        sclk_next  = sclk_reg;
        data_next  = data_reg;
        gate_next  = gate_reg;
        taken_next = 1'b0;
        row_next   = row_reg;
        case (state_reg)
            HST_IDLE: begin
                if (frm_sync_reg && !frm_last_reg) begin
                    state_next = HST_GUARD;
                    guard_next = '0;
                end
            end
            HST_GUARD: begin
                guard_next = guard_reg + `GUARD_CNT_W'(1);
                if (guard_reg == `GUARD_CNT_W'(`GUARD_CYC - 1)) begin
                    word_next = {col_valid_i ? col_data_i : 16'h0000,
                                 16'h0001 << row_reg};
                    taken_next = col_valid_i;
                    gate_next  = 1'b1;
                    bit_next   = 6'd32;
                    half_next  = '0;
                    state_next = HST_LOAD;
                end
            end
            HST_LOAD: begin
                half_next = half_reg + `HALF_CNT_W'(1);
                if (half_reg == '0 && sclk_reg) begin
                    data_next = word_reg[`CHAIN_LEN-1];
                    word_next = {word_reg[`CHAIN_LEN-2:0], 1'b0};
                end
                if (half_reg == `HALF_CNT_W'(`SCLK_HALF_CYC - 1)) begin
                    half_next = '0;
                    sclk_next = ~sclk_reg;
                    if (sclk_reg) begin
                        bit_next = bit_reg - 6'd1;  // falling edge
                    end else if (bit_reg == 6'd0) begin
                        gate_next  = 1'b0;          // last rise done
                        data_next  = 1'b0;
                        row_next   = row_reg + `ROW_IDX_W'(1);
                        state_next = HST_IDLE;
                    end
                end
            end
            default: begin
                state_next = HST_IDLE;
            end
        endcase
        busy_next = (state_next != HST_IDLE);  // registered busy flag
    end

    // sequence registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= HST_IDLE;
            guard_reg <= '0;
            half_reg  <= '0;
            bit_reg   <= '0;
            word_reg  <= '0;
            sclk_reg  <= 1'b1;
            data_reg  <= 1'b0;
            gate_reg  <= 1'b0;
            taken_reg <= 1'b0;
            row_reg   <= '0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            guard_reg <= guard_next;
            half_reg  <= half_next;
            bit_reg   <= bit_next;
            word_reg  <= word_next;
            sclk_reg  <= sclk_next;
            data_reg  <= data_next;
            gate_reg  <= gate_next;
            taken_reg <= taken_next;
            row_reg   <= row_next;
            busy_reg  <= busy_next;
        end
    end

    assign link.shift_clk        = sclk_reg;
    assign link.serial_data      = data_reg;
    assign link.shift_clock_gate = gate_reg;
    assign link.phase_host_out   = ph_reg;
    assign link.phase_host_oe    = ph_oe_reg;
    assign col_taken_o           = taken_reg;
    assign row_index_o           = row_reg;
    assign busy_o                = busy_reg;

endmodule

/* File: lcd_link_monitor.sv */
// checker on the link wires between display driver and controller
`timescale 1ns/1ps
`include "lcd_link_cfg.svh"
module lcd_link_monitor #(
    parameter int FRAME_HALF_CYC = `FRAME_HALF_CYC  // phase half period
)(
    input wire logic ref_clk_i,           // core clock
    input wire logic resetn_i,            // reset, low
    input wire logic shift_clk,           // shift clock
    input wire logic serial_data,         // serial bit
    input wire logic shift_clock_gate,    // shift gate
    input wire logic frame_request,       // refresh request
    input wire logic phase_host_oe,       // host drives phase
    input wire logic backplane_phase_pin  // phase pin
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [5:0]  nb_reg, nb_next;           // falls in one load
    logic [15:0] len_reg, len_next;         // cycles since frame edge
    logic [1:0]  sn_reg, sn_next;           // frame edges seen
    logic        sc_reg, fr_reg, oe_reg;    // last samples
    // helper counters
    always_comb begin
        nb_next = shift_clock_gate ? nb_reg + 6'(sc_reg & ~shift_clk) : 6'h0;
        len_next = (frame_request != fr_reg) ? 16'h0 : len_reg + 16'h1;
        sn_next = sn_reg;
        if (phase_host_oe != oe_reg) sn_next = 2'h0;
        else if (frame_request != fr_reg && sn_reg != 2'h2)
            sn_next = sn_reg + 2'h1;
    end
    // register helpers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {nb_reg, len_reg, sn_reg} <= '0;
            {sc_reg, fr_reg, oe_reg} <= 3'h4;
        end else begin
            {nb_reg, len_reg, sn_reg} <= {nb_next, len_next, sn_next};
            {sc_reg, fr_reg, oe_reg} <=
                {shift_clk, frame_request, phase_host_oe};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_quiet; (shift_clk && !shift_clock_gate) [*8]; endsequence
    property p_rise; $rose(backplane_phase_pin) |-> ##[1:4] frame_request;
    endproperty
    property p_fall; $fell(backplane_phase_pin) |-> ##[1:4] !frame_request;
    endproperty
    property p_gate; $fell(shift_clk) |-> shift_clock_gate; endproperty
    property p_setup; $fell(shift_clk) |-> $stable(serial_data); endproperty
    property p_hold; $fell(shift_clk) |=> $stable(serial_data); endproperty
    property p_quiet; $rose(frame_request) |-> s_quiet; endproperty
    property p_count; $fell(shift_clock_gate) |-> nb_reg == 6'h20; endproperty
    property p_duty; frame_request != fr_reg && sn_reg == 2'h2
        |-> len_reg == FRAME_HALF_CYC - 1; endproperty
    a_rise: assert property (p_rise) else $error("frame rise late");
    a_fall: assert property (p_fall) else $error("frame fall late");
    a_gate: assert property (p_gate) else $error("shift ungated");
    a_setup: assert property (p_setup) else $error("data moved");
    a_hold: assert property (p_hold) else $error("data hold");
    a_quiet: assert property (p_quiet) else $error("shift near rise");
    a_count: assert property (p_count) else $error("bit count");
    a_duty: assert property (p_duty) else $error("frame duty");
endmodule

/* File: tb_top.sv */
// bench joining the display driver to its controller
`timescale 1ns/1ps
`include "lcd_link_cfg.svh"
module tb_top
    import lcd_link_pkg::*;
;
    localparam int HALF = 600;               // shortened half period
    logic ref_clk_i, resetn_i, drive_phase_i, col_valid_i, col_taken_o;
    logic busy_o, bsy, tk, rst, busy_q, fr_q, cur_ok, fr;
    logic [15:0] col_data_i, col_high_o;     // columns in and out
    logic [3:0] row_index_o, exp_row;        // row being loaded
    logic [19:0] cur, notes [$];             // {row, columns} per load
    drive_level_e row_level_o [16];          // row driver levels
    int fail_count, n_checks, seed, rises;
    lcd_link_if link ();
    matrix_drv_device #(.FRAME_HALF_CYC(HALF)) i_matrix_drv_device (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link),
        .row_level_o(row_level_o), .col_high_o(col_high_o));
    matrix_drv_host #(.FRAME_HALF_CYC(HALF)) i_matrix_drv_host (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(link),
        .drive_phase_i(drive_phase_i), .col_data_i(col_data_i),
        .col_valid_i(col_valid_i), .col_taken_o(col_taken_o),
        .row_index_o(row_index_o), .busy_o(busy_o));
    lcd_link_monitor #(.FRAME_HALF_CYC(HALF)) i_lcd_link_monitor (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .shift_clk(link.shift_clk), .serial_data(link.serial_data),
        .shift_clock_gate(link.shift_clock_gate),
        .frame_request(link.frame_request),
        .phase_host_oe(link.phase_host_oe),
        .backplane_phase_pin(link.backplane_phase_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] e, a);
        n_checks++;
        if (a !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, a);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // oscillator phase, second reset, then host-driven phase
    initial begin
        {fail_count, n_checks, rises} = '0;
        {resetn_i, drive_phase_i, busy_q, fr_q, cur_ok, exp_row} = '0;
        col_valid_i = 1'b1;
        col_data_i = 16'hFFFF;
        seed = 50;
        repeat (2) @(posedge ref_clk_i);
        #2 resetn_i = 1'b1;
        wait (rises == 10);
        @(posedge ref_clk_i);
        #2 resetn_i = 1'b0;
        drive_phase_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #2 resetn_i = 1'b1;
        wait (rises == 22);
        results();
    end
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        fail_count++;
        results();
    end
    // note each accepted row and offer new columns
    always @(posedge ref_clk_i) begin
        {bsy, tk, rst} = {busy_o, col_taken_o, resetn_i};
        #2;
        if (rst !== 1'b1) begin
            {busy_q, exp_row} = '0;
        end else begin
            // every load selects its row; columns zero unless taken
            if (busy_q === 1'b0 && bsy === 1'b1) begin
                notes.push_back({exp_row, 16'h0000});
            end
            if (tk === 1'b1) begin
                check("row index", 16'(exp_row), 16'(row_index_o));
                notes[notes.size() - 1] = {exp_row, col_data_i};
                col_data_i = 16'($random(seed));
            end
            if (busy_q === 1'b1 && bsy === 1'b0) begin
                exp_row = exp_row + 4'h1;
                col_valid_i = ($random(seed) % 4) != 0;
            end
            busy_q = bsy;
        end
    end
    // compare latched outputs at each frame edge once a noted load is due
    always @(posedge ref_clk_i) begin
        #1;
        fr = link.frame_request;
        if (resetn_i !== 1'b1) begin
            {fr_q, cur_ok} = 2'h0;
            notes.delete();
        end else if (fr !== fr_q) begin
            fr_q = fr;
            if (fr === 1'b1) begin
                rises++;
                cur_ok = notes.size() > 0;
                if (cur_ok) cur = notes.pop_front();
            end
            if (cur_ok) begin
                check("cols", fr ? cur[15:0] : ~cur[15:0],
                      col_high_o);
                for (int r = 0; r < 16; r++)
                    check("row", (r != cur[19:16]) ? 16'(LVL_MID) :
                          fr ? 16'(LVL_LOW) : 16'(LVL_HIGH),
                          16'(row_level_o[r]));
            end
        end
    end
endmodule
